// >>> verilog/rcic_params.svh
// register offsets, field positions, reset values and vectors of the reset/irq controller
`ifndef RCIC_PARAMS_SVH
`define RCIC_PARAMS_SVH
`define RCIC_OFS_IRQCTL 4'h0
`define RCIC_OFS_PFLAGS 4'h1
`define RCIC_OFS_PMASKS 4'h2
`define RCIC_OFS_STATUS 4'h3
`define RCIC_OFS_PWRCTL 4'h4
`define RCIC_OFS_EVST 4'h5
`define RCIC_OFS_EVMASK 4'h6
`define RCIC_B_GIE 7
`define RCIC_B_PEIE 6
`define RCIC_B_TMR_EN 5
`define RCIC_B_EXT_EN 4
`define RCIC_B_PCH_EN 3
`define RCIC_B_TMR_FL 2
`define RCIC_B_EXT_FL 1
`define RCIC_B_PCH_FL 0
`define RCIC_B_ADC 0
`define RCIC_B_TO 4
`define RCIC_B_PD 3
`define RCIC_B_MIRROR 7
`define RCIC_B_PER 2
`define RCIC_B_POR 1
`define RCIC_B_BOR 0
`define RCIC_B_EV_VEC 0
`define RCIC_B_EV_WAKE 1
`define RCIC_B_EV_RST 2
`define RCIC_EV_W 3
`define RCIC_IRQ_VEC 13'h0004
`define RCIC_RST_VEC 13'h0000
`define RCIC_PC_STEP 13'h0001
`define RCIC_EXT_LAT 2'h3
`define RCIC_BOR_POR_VAL 1'b0
`define RCIC_STACK_DEPTH 8
`endif

// >>> verilog/rcic_pkg.sv
// types shared by the reset/irq controller
package rcic_pkg;
	typedef enum logic [2:0] {
		RC_NONE, RC_BOR, RC_WDT_RST, RC_WDT_WAKE, RC_MASTER_CLEAR_PIN, RC_MASTER_CLEAR_PIN_SLEEP, RC_PARITY, RC_IRQ_WAKE
	} rcic_cause_type;
	typedef logic [12:0] rcic_pc_type;
	typedef logic [7:0] rcic_byte_type;
endpackage

// >>> verilog/rcic_flag_bank.sv
// sticky event flags, set by hardware, cleared by writing one
`timescale 1ns/1ns
`include "rcic_params.svh"
module rcic_flag_bank (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [`RCIC_EV_W-1:0] set_in,
	input wire logic [`RCIC_EV_W-1:0] clr_in,
	output logic [`RCIC_EV_W-1:0] flags_out
);
	logic [`RCIC_EV_W-1:0] flag_d;
	genvar gi;
	generate
		for (gi = 0; gi < `RCIC_EV_W; gi++) begin : g_bit
			// set beats a clear in the same cycle
			always_comb begin
				flag_d[gi] = set_in[gi] | (flags_out[gi] & ~clr_in[gi]);
			end
		end
	endgenerate
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			flags_out <= '0;
		end else if (ce_in) begin
			flags_out <= flag_d;
		end
	end
	a_set_wins: assert property (@(posedge core_clk_in) disable iff (rst_in)
		ce_in && set_in[0] |=> flags_out[0]) else $error("event flag lost on clear");
endmodule // rcic_flag_bank

// >>> verilog/rcic_ext_delay.sv
// ages an external event over instruction boundaries before it may vector
`timescale 1ns/1ns
`include "rcic_params.svh"
module rcic_ext_delay (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic evt_in,
	input wire logic instr_cycle_in,
	input wire logic flag_in,
	output logic ready_out
);
	logic [1:0] cnt_q, cnt_d;
	logic armed_q, armed_d;
	always_comb begin
		cnt_d = cnt_q;
		armed_d = armed_q & flag_in;
		if (evt_in) begin
			cnt_d = 2'h0;
			armed_d = 1'b1;
		end else if (armed_q && instr_cycle_in && cnt_q != `RCIC_EXT_LAT) begin
			cnt_d = cnt_q + 2'h1;
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			cnt_q <= 2'h0;
			armed_q <= 1'b0;
		end else if (ce_in) begin
			cnt_q <= cnt_d;
			armed_q <= armed_d;
		end
	end
	assign ready_out = armed_q && cnt_q == `RCIC_EXT_LAT && flag_in;
	a_ext_not_early: assert property (@(posedge core_clk_in) disable iff (rst_in)
		ce_in && evt_in |=> !ready_out) else $error("external event ready too early");
endmodule // rcic_ext_delay

// >>> verilog/rcic_top.sv
// reset-cause recording and interrupt vectoring controller
`timescale 1ns/1ns
`include "rcic_params.svh"
module rcic_top #(
	parameter bit OLD_VARIANT = 1'b1
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [3:0] reg_addr_in,
	input wire rcic_pkg::rcic_byte_type reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic ext_edge_evt_in,
	input wire logic timer_ovf_evt_in,
	input wire logic port_change_evt_in,
	input wire logic adc_done_evt_in,
	input wire logic instr_cycle_in,
	input wire logic return_from_irq_in,
	input wire rcic_pkg::rcic_pc_type pc_in,
	input wire logic sleeping_in,
	input wire logic master_clear_pin_rst_in,
	input wire logic wdt_timeout_in,
	input wire logic bor_rst_in,
	input wire logic parity_err_in,
	input wire logic parity_check_enable_in,
	input wire logic brownout_detect_enable_in,
	output rcic_pkg::rcic_byte_type reg_rdata_out,
	output logic pc_load_out,
	output rcic_pkg::rcic_pc_type pc_value_out,
	output logic vector_out,
	output logic wake_out,
	output logic gie_out,
	output logic irq_out
);
	import rcic_pkg::*;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		hit = a == ofs;
	endfunction

	function automatic rcic_cause_type cause_of(input logic bor, input logic par, input logic master_clear_pin,
			input logic wdt, input logic slp, input logic wake);
		if (bor) cause_of = RC_BOR;
		else if (par) cause_of = RC_PARITY;
		else if (master_clear_pin) cause_of = slp ? RC_MASTER_CLEAR_PIN_SLEEP : RC_MASTER_CLEAR_PIN;
		else if (wdt) cause_of = slp ? RC_WDT_WAKE : RC_WDT_RST;
		else if (wake) cause_of = RC_IRQ_WAKE;
		else cause_of = RC_NONE;
	endfunction

	rcic_byte_type ictl_q, ictl_d, pfl_q, pfl_d, pmk_q, pmk_d;
	logic to_q, to_d, pd_q, pd_d, per_q, per_d, por_q, por_d, bor_q, bor_d;
	logic [`RCIC_EV_W-1:0] evmask_q, evmask_d, ev_set, ev_clr, ev_flags;
	rcic_byte_type rdata_d;
	logic pcl_d, vec_d, wake_d, irq_d;
	rcic_pc_type pcv_d;
	rcic_pc_type stack_q [`RCIC_STACK_DEPTH];
	logic [2:0] sp_q, sp_d;
	logic push, pop;
	rcic_pc_type push_val;
	logic ext_rdy, pch_rdy, any_ready, any_pend, take, gie_clr_wr;
	rcic_cause_type cause;

	// external sources only qualify for a vector while awake after aging; a wake from sleep uses the raw flag
	rcic_ext_delay u_ext_delay (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.evt_in(ext_edge_evt_in),
		.instr_cycle_in(instr_cycle_in),
		.flag_in(ictl_q[`RCIC_B_EXT_FL]),
		.ready_out(ext_rdy)
	);
	rcic_ext_delay u_pch_delay (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.evt_in(port_change_evt_in),
		.instr_cycle_in(instr_cycle_in),
		.flag_in(ictl_q[`RCIC_B_PCH_FL]),
		.ready_out(pch_rdy)
	);
	rcic_flag_bank u_evst (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.set_in(ev_set),
		.clr_in(ev_clr),
		.flags_out(ev_flags)
	);

	always_comb begin
		any_pend = (ictl_q[`RCIC_B_TMR_FL] & ictl_q[`RCIC_B_TMR_EN])
			| (ictl_q[`RCIC_B_EXT_FL] & ictl_q[`RCIC_B_EXT_EN])
			| (ictl_q[`RCIC_B_PCH_FL] & ictl_q[`RCIC_B_PCH_EN])
			| (ictl_q[`RCIC_B_PEIE] & pfl_q[`RCIC_B_ADC] & pmk_q[`RCIC_B_ADC]);
		any_ready = (ictl_q[`RCIC_B_TMR_FL] & ictl_q[`RCIC_B_TMR_EN])
			| (ext_rdy & ictl_q[`RCIC_B_EXT_EN])
			| (pch_rdy & ictl_q[`RCIC_B_PCH_EN])
			| (ictl_q[`RCIC_B_PEIE] & pfl_q[`RCIC_B_ADC] & pmk_q[`RCIC_B_ADC]);
		gie_clr_wr = reg_wr_in && hit(reg_addr_in, `RCIC_OFS_IRQCTL) && !reg_wdata_in[`RCIC_B_GIE];
		cause = cause_of(bor_rst_in, parity_err_in, master_clear_pin_rst_in, wdt_timeout_in, sleeping_in,
			sleeping_in && any_pend);
		take = ictl_q[`RCIC_B_GIE] && any_ready && instr_cycle_in && !sleeping_in
			&& (OLD_VARIANT || !gie_clr_wr) && cause == RC_NONE;
	end

	always_comb begin
		ictl_d = ictl_q;
		pfl_d = pfl_q;
		pmk_d = pmk_q;
		evmask_d = evmask_q;
		to_d = to_q;
		pd_d = pd_q;
		per_d = per_q;
		por_d = por_q;
		bor_d = bor_q;
		ev_clr = '0;
		if (reg_wr_in) begin
			if (hit(reg_addr_in, `RCIC_OFS_IRQCTL)) ictl_d = reg_wdata_in;
			if (hit(reg_addr_in, `RCIC_OFS_PFLAGS)) pfl_d = reg_wdata_in;
			if (hit(reg_addr_in, `RCIC_OFS_PMASKS)) pmk_d = reg_wdata_in;
			if (hit(reg_addr_in, `RCIC_OFS_EVMASK)) evmask_d = reg_wdata_in[`RCIC_EV_W-1:0];
			if (hit(reg_addr_in, `RCIC_OFS_EVST)) ev_clr = reg_wdata_in[`RCIC_EV_W-1:0];
			if (hit(reg_addr_in, `RCIC_OFS_PWRCTL)) begin
				per_d = reg_wdata_in[`RCIC_B_PER];
				por_d = reg_wdata_in[`RCIC_B_POR];
				bor_d = reg_wdata_in[`RCIC_B_BOR];
			end
		end
		// hardware sets win over software writes
		if (timer_ovf_evt_in) ictl_d[`RCIC_B_TMR_FL] = 1'b1;
		if (ext_edge_evt_in) ictl_d[`RCIC_B_EXT_FL] = 1'b1;
		if (port_change_evt_in) ictl_d[`RCIC_B_PCH_FL] = 1'b1;
		if (adc_done_evt_in) pfl_d[`RCIC_B_ADC] = 1'b1;
		if (return_from_irq_in) ictl_d[`RCIC_B_GIE] = 1'b1;
		if (take) ictl_d[`RCIC_B_GIE] = 1'b0;
		unique case (cause)
			RC_NONE: begin
			end
			RC_BOR: begin
				bor_d = 1'b0;
				per_d = 1'b1;
				to_d = 1'b1;
				pd_d = 1'b1;
			end
			RC_PARITY: begin
				per_d = 1'b0;
			end
			RC_MASTER_CLEAR_PIN: begin
			end
			RC_MASTER_CLEAR_PIN_SLEEP: begin
				to_d = 1'b1;
				pd_d = 1'b0;
			end
			RC_WDT_RST: begin
				to_d = 1'b0;
				pd_d = 1'b1;
			end
			RC_WDT_WAKE: begin
				to_d = 1'b0;
				pd_d = 1'b0;
			end
			RC_IRQ_WAKE: begin
				to_d = 1'b1;
				pd_d = 1'b0;
			end
		endcase
		if (cause != RC_NONE && cause != RC_WDT_WAKE && cause != RC_IRQ_WAKE) begin
			ictl_d[`RCIC_B_GIE] = 1'b0;
		end
		if (cause == RC_IRQ_WAKE && ictl_q[`RCIC_B_GIE]) ictl_d[`RCIC_B_GIE] = 1'b0;
	end

	always_comb begin
		pcl_d = 1'b0;
		pcv_d = pc_value_out;
		vec_d = 1'b0;
		wake_d = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		push_val = pc_in;
		ev_set = '0;
		if (cause == RC_WDT_WAKE || cause == RC_IRQ_WAKE) begin
			pcl_d = 1'b1;
			wake_d = 1'b1;
			pcv_d = pc_in + `RCIC_PC_STEP;
			ev_set[`RCIC_B_EV_WAKE] = 1'b1;
			if (cause == RC_IRQ_WAKE && ictl_q[`RCIC_B_GIE]) begin
				pcv_d = `RCIC_IRQ_VEC;
				vec_d = 1'b1;
				push = 1'b1;
				push_val = pc_in + `RCIC_PC_STEP;
				ev_set[`RCIC_B_EV_VEC] = 1'b1;
			end
		end else if (cause != RC_NONE) begin
			pcl_d = 1'b1;
			pcv_d = `RCIC_RST_VEC;
			ev_set[`RCIC_B_EV_RST] = 1'b1;
		end else if (take) begin
			pcl_d = 1'b1;
			pcv_d = `RCIC_IRQ_VEC;
			vec_d = 1'b1;
			push = 1'b1;
			ev_set[`RCIC_B_EV_VEC] = 1'b1;
		end else if (return_from_irq_in) begin
			pcl_d = 1'b1;
			pop = 1'b1;
			pcv_d = stack_q[sp_q - 3'h1];
		end
		sp_d = push ? sp_q + 3'h1 : (pop ? sp_q - 3'h1 : sp_q);
		irq_d = |(ev_flags & evmask_q);
	end

	always_comb begin
		rdata_d = 8'h00;
		if (reg_rd_in) begin
			unique case (1'b1)
				hit(reg_addr_in, `RCIC_OFS_IRQCTL): rdata_d = ictl_q;
				hit(reg_addr_in, `RCIC_OFS_PFLAGS): rdata_d = pfl_q;
				hit(reg_addr_in, `RCIC_OFS_PMASKS): rdata_d = pmk_q;
				hit(reg_addr_in, `RCIC_OFS_STATUS): begin
					rdata_d[`RCIC_B_TO] = to_q;
					rdata_d[`RCIC_B_PD] = pd_q;
				end
				hit(reg_addr_in, `RCIC_OFS_PWRCTL): begin
					rdata_d[`RCIC_B_MIRROR] = parity_check_enable_in;
					rdata_d[`RCIC_B_PER] = per_q;
					rdata_d[`RCIC_B_POR] = por_q;
					// brownout flag means nothing while the detector is off
					rdata_d[`RCIC_B_BOR] = bor_q & brownout_detect_enable_in;
				end
				hit(reg_addr_in, `RCIC_OFS_EVST): rdata_d[`RCIC_EV_W-1:0] = ev_flags;
				hit(reg_addr_in, `RCIC_OFS_EVMASK): rdata_d[`RCIC_EV_W-1:0] = evmask_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			ictl_q <= 8'h00;
			pfl_q <= 8'h00;
			pmk_q <= 8'h00;
			evmask_q <= '0;
			to_q <= 1'b1;
			pd_q <= 1'b1;
			per_q <= 1'b1;
			por_q <= 1'b0;
			bor_q <= `RCIC_BOR_POR_VAL;
			sp_q <= 3'h0;
			reg_rdata_out <= 8'h00;
			pc_load_out <= 1'b1;
			pc_value_out <= `RCIC_RST_VEC;
			vector_out <= 1'b0;
			wake_out <= 1'b0;
			irq_out <= 1'b0;
		end else if (ce_in) begin
			ictl_q <= ictl_d;
			pfl_q <= pfl_d;
			pmk_q <= pmk_d;
			evmask_q <= evmask_d;
			to_q <= to_d;
			pd_q <= pd_d;
			per_q <= per_d;
			por_q <= por_d;
			bor_q <= bor_d;
			sp_q <= sp_d;
			reg_rdata_out <= rdata_d;
			pc_load_out <= pcl_d;
			pc_value_out <= pcv_d;
			vector_out <= vec_d;
			wake_out <= wake_d;
			irq_out <= irq_d;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (ce_in && push && !rst_in) begin
			stack_q[sp_q] <= push_val;
		end
	end

	assign gie_out = ictl_q[`RCIC_B_GIE];

	a_take_vector: assert property (@(posedge core_clk_in) disable iff (rst_in)
		ce_in && take |=> vector_out && pc_load_out && pc_value_out == `RCIC_IRQ_VEC
		&& !gie_out) else $error("accepted interrupt did not vector");
	a_gie_blocks: assert property (@(posedge core_clk_in) disable iff (rst_in)
		ce_in && !gie_out && !sleeping_in |=> !vector_out) else $error("vector with enable clear");
	a_ret_sets_gie: assert property (@(posedge core_clk_in) disable iff (rst_in)
		ce_in && return_from_irq_in && cause == RC_NONE && !take |=> gie_out && pc_load_out
		&& pc_value_out == stack_q[sp_q]) else $error("return did not restore");
	a_flag_sets: assert property (@(posedge core_clk_in) disable iff (rst_in)
		ce_in && timer_ovf_evt_in |=> ictl_q[`RCIC_B_TMR_FL]) else $error("timer flag not set");
	a_reset_pc_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
		ce_in && (bor_rst_in || parity_err_in || master_clear_pin_rst_in || (wdt_timeout_in && !sleeping_in))
		|=> pc_load_out && pc_value_out == `RCIC_RST_VEC && !gie_out) else $error("reset vector wrong");
	a_master_clear_pin_keeps: assert property (@(posedge core_clk_in) disable iff (rst_in)
		ce_in && cause == RC_MASTER_CLEAR_PIN |=> $stable(to_q) && $stable(pd_q)) else $error("status changed");
	a_wdt_flags: assert property (@(posedge core_clk_in) disable iff (rst_in)
		ce_in && cause == RC_WDT_RST |=> !to_q && pd_q) else $error("watchdog status wrong");
	a_bor_flags: assert property (@(posedge core_clk_in) disable iff (rst_in)
		ce_in && bor_rst_in |=> por_q == $past(por_q) && !bor_q && per_q) else $error("brown-out flags");
	a_parity_clr: assert property (@(posedge core_clk_in) disable iff (rst_in)
		ce_in && cause == RC_PARITY |=> !per_q ##1 !ce_in || reg_wr_in || !per_q)
		else $error("parity flag not cleared");
	a_wake_pc: assert property (@(posedge core_clk_in) disable iff (rst_in)
		ce_in && cause == RC_WDT_WAKE |=> wake_out && pc_value_out == $past(pc_in) + `RCIC_PC_STEP)
		else $error("wake address wrong");
endmodule // rcic_top

// >>> verif/rcic_core_model.sv
// core sequencer stand-in: instruction boundaries and program counter
`timescale 1ns/1ns
module rcic_core_model (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic sleeping_in,
	input wire logic pc_load_in,
	input wire rcic_pkg::rcic_pc_type pc_value_in,
	output logic instr_cycle_out,
	output rcic_pkg::rcic_pc_type pc_out
);
	import rcic_pkg::*;
	logic [1:0] phase_q;
	// four clocks an instruction, frozen while asleep
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			phase_q <= 2'h0;
			pc_out <= 13'h0000;
		end else begin
			if (!sleeping_in)
				phase_q <= phase_q + 2'h1;
			if (pc_load_in)
				pc_out <= pc_value_in;
			else if (instr_cycle_out)
				pc_out <= pc_out + 13'h0001;
		end
	end
	assign instr_cycle_out = (phase_q == 2'h3) && !sleeping_in;
endmodule // rcic_core_model

// >>> verif/tb.sv
// self-checking bench of the reset/irq controller
`timescale 1ns/1ns
`include "rcic_params.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; $display("MISMATCH %0t got %0h want %0h", $time, a, e); end end
module tb;
	import rcic_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sleeping = 1'b0;
	logic reg_rd = 1'b0;
	logic reg_wr = 1'b0;
	logic [3:0] addr = 4'h0;
	rcic_byte_type wdata = 8'h00;
	logic [8:0] ev = 9'h000;
	rcic_byte_type rdata;
	logic pc_load, vec, wake, global_irq_enable, irq, icyc;
	rcic_pc_type pcv, pc, e;
	int err_total = 0;
	int compares = 0;
	int cycles = 0;
	int vec_cnt = 0;
	int i, n, s, k;
	rcic_pc_type q[$];
	logic [31:0] seed = 32500;
	logic [7:0] d;
	logic [1:0] m_st = 2'b11;
	logic [2:0] m_pw = 3'b111;
	logic [7:0] ctl [4] = '{8'h90, 8'hA0, 8'h88, 8'hC0};
	int cz [6] = '{5, 4, 4, 5, 6, 7};
	bit slp [6] = '{0, 0, 1, 1, 0, 0};

	rcic_top dut (.core_clk_in(clk), .rst_in(rst), .ce_in(1'b1), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .ext_edge_evt_in(ev[0]), .timer_ovf_evt_in(ev[1]),
		.port_change_evt_in(ev[2]), .adc_done_evt_in(ev[3]), .instr_cycle_in(icyc), .return_from_irq_in(ev[8]),
		.pc_in(pc), .sleeping_in(sleeping), .master_clear_pin_rst_in(ev[4]), .wdt_timeout_in(ev[5]), .bor_rst_in(ev[6]),
		.parity_err_in(ev[7]), .parity_check_enable_in(1'b1), .brownout_detect_enable_in(1'b1),
		.reg_rdata_out(rdata), .pc_load_out(pc_load), .pc_value_out(pcv), .vector_out(vec),
		.wake_out(wake), .gie_out(global_irq_enable), .irq_out(irq));
	rcic_core_model u_core (.core_clk_in(clk), .rst_in(rst), .sleeping_in(sleeping), .pc_load_in(pc_load),
		.pc_value_in(pcv), .instr_cycle_out(icyc), .pc_out(pc));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic results();
		if (err_total == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic pulse(input int b);
		@(posedge clk);
		ev[b] <= 1'b1;
		@(posedge clk);
		ev[b] <= 1'b0;
		#1;
	endtask
	task automatic wait_load();
		for (int j = 0; j < 6 && pc_load !== 1'b1; j++) begin
			@(posedge clk);
			#1;
		end
	endtask

	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (vec === 1'b1)
			vec_cnt++;
		if (cycles == 5000) begin
			err_total++;
			results();
		end
	end

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(4'h3, d);
		`CHK(d[4:3], 2'b11)
		rd(4'h4, d);
		`CHK(d[7:1], 7'h42)
		`CHK(global_irq_enable, 1'b0)
		rd(4'h7, d);
		`CHK(d, 8'h00)
		d = rnd();
		wr(4'h2, d);
		rd(4'h2, k);
		`CHK(k[7:0], d)
		// flags latch with every enable off, then nothing vectors
		wr(4'h2, 8'h00);
		wr(4'h0, 8'h00);
		s = vec_cnt;
		for (i = 0; i < 4; i++)
			pulse(i);
		rd(4'h0, d);
		`CHK(d[2:0], 3'h7)
		rd(4'h1, d);
		`CHK(d[0], 1'b1)
		wr(4'h0, 8'h87);
		repeat (12) @(posedge clk);
		wr(4'h0, 8'h7F);
		repeat (12) @(posedge clk);
		`CHK(vec_cnt, s)
		wr(4'h0, 8'h00);
		wr(4'h1, 8'h00);
		// each source vectors, then returns
		for (i = 0; i < 4; i++) begin
			wr(4'h2, {7'h00, i == 3});
			wr(4'h0, ctl[i]);
			pulse(i);
			n = 0;
			for (k = 0; k < 40 && vec !== 1'b1; k++) begin
				if (icyc === 1'b1)
					n++;
				@(posedge clk);
				#1;
			end
			`CHK(n >= (i % 2 == 0 ? 3 : 0) && n <= (i % 2 == 0 ? 4 : 1), 1'b1)
			`CHK({pc_load, pcv, global_irq_enable}, {1'b1, `RCIC_IRQ_VEC, 1'b0})
			q.push_back(pc - 13'h0001);
			wr(4'h0, 8'h00);
			wr(4'h1, 8'h00);
			pulse(8);
			wait_load();
			`CHK({pcv, global_irq_enable}, {q.pop_back(), 1'b1})
		end
		`CHK(irq, 1'b0)
		wr(4'h6, 8'h01);
		repeat (2) @(posedge clk);
		#1 `CHK(irq, 1'b1)
		wr(4'h5, 8'h07);
		repeat (2) @(posedge clk);
		#1 `CHK(irq, 1'b0)
		wr(4'h4, 8'h07);
		// reset causes against the status model
		for (i = 0; i < 6; i++) begin
			wr(4'h0, 8'h80);
			sleeping <= slp[i];
			@(posedge clk);
			#1 e = (slp[i] && cz[i] == 5) ? pc + 13'h0001 : `RCIC_RST_VEC;
			pulse(cz[i]);
			wait_load();
			`CHK(pcv, e)
			`CHK(global_irq_enable, slp[i] && cz[i] == 5)
			@(posedge clk);
			sleeping <= 1'b0;
			case (cz[i])
				4: if (slp[i]) m_st = 2'b10;
				5: m_st = {1'b0, ~slp[i]};
				6: begin
					m_st = 2'b11;
					m_pw[0] = 1'b0;
				end
				// parity reset leaves the status bits as they were
				default: begin
					m_pw[2] = 1'b0;
				end
			endcase
			rd(4'h3, d);
			`CHK(d[4:3], m_st)
			rd(4'h4, d);
			`CHK(d[2:0], m_pw)
		end
		// interrupt wake: vector with enable, next address without
		for (i = 0; i < 2; i++) begin
			wr(4'h0, {i[0], 7'h20});
			sleeping <= 1'b1;
			@(posedge clk);
			#1 e = i ? `RCIC_IRQ_VEC : pc + 13'h0001;
			pulse(1);
			wait_load();
			`CHK({pcv, wake}, {e, 1'b1})
			@(posedge clk);
			sleeping <= 1'b0;
			wr(4'h0, 8'h00);
		end
		results();
	end
endmodule // tb
